// file: e3oh_tx_overhead.sv
// E3 transmit overhead insertion port with frame timing and payload serialiser
//
// Summary of operation
// - Overhead bit strobe goes high just before each overhead bit is processed.
// - Both strobes high together only before the first overhead bit of a frame.
// - Counts 0 to 15 are framing bytes one and two, never insertable.
// - Counts 16 to 23 are error monitor bits, external values refused.
// - Counts 24 to 31 are trail trace bits, insertable.
// - Counts 32 to 39 are maintenance adaptation bits; 32 is far end receive failure.
// - Count 33 is far end block error, insertable.
// - Counts 40 to 55 are network operator and general channel bits, insertable.
// - Overhead strobe is high one clock per overhead bit, eight clocks in a row for each byte and sixteen for the two framing bytes, just before the bit.
// - Data sampled only while insert request is high.
// - Requests at non-insertable positions are silently ignored.
// - Accepted bit goes into the same position of the very next frame.
`timescale 1ns/1ns
`include "e3oh_regs.svh"
`default_nettype none
module e3oh_tx_overhead #(
  parameter int FIFO_WIDTH = 8,
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic                  overheadInsertRequest,
  input  wire logic                  overheadDataInput,
  output logic                       frameBoundaryStrobe,
  output logic                       overheadBitStrobe,
  input  wire logic [FIFO_WIDTH-1:0] payloadData,
  input  wire logic                  payloadValid,
  output logic                       payloadReady,
  output logic                       txLineData,
  output logic                       txLineFrameStart
);
  // Frame layout: 9 rows of 59 bytes; overhead is two bytes of row 0 and byte 0 of rows 1 to 5
  function automatic logic isOhPos(input logic [3:0] row, input logic [5:0] col);
    isOhPos = ((row == 4'h0) && (col <= 6'h01)) || ((row != 4'h0) && (row <= `E3OH_OH_ROW_LAST) && (col == 6'h00));
  endfunction

  function automatic logic isInsertable(input e3oh_pkg::e3oh_idx_t idx);
    isInsertable = (idx >= `E3OH_FIRST_INS_IDX) && (idx <= `E3OH_LAST_INS_IDX);
  endfunction

  function automatic e3oh_pkg::e3oh_byte_t defaultByte(input logic [2:0] sel);
    case (sel)
      3'h0:    defaultByte = `E3OH_FA1_VALUE;
      3'h1:    defaultByte = `E3OH_FA2_VALUE;
      3'h3:    defaultByte = `E3OH_TR_DEFAULT;
      3'h4:    defaultByte = `E3OH_MA_DEFAULT;
      3'h5:    defaultByte = `E3OH_NR_DEFAULT;
      3'h6:    defaultByte = `E3OH_GC_DEFAULT;
      default: defaultByte = 8'h00;
    endcase
  endfunction

  // Lead position counters, one clock ahead of processing
  logic [2:0]             bitCnt_r;
  logic [5:0]             colCnt_r;
  logic [3:0]             rowCnt_r;
  e3oh_pkg::e3oh_idx_t    ohCnt_r;
  e3oh_pkg::e3oh_idx_t    s1Idx_r;
  logic [2:0]             s1Bit_r;
  logic [7:0]             payShift_r;
  logic [7:0]             bipAcc_r;
  logic [7:0]             bipPrev_r;
  logic                   lineLive_r;
  logic [`E3OH_OH_BITS-1:0] pendFlag_r;
  logic [`E3OH_OH_BITS-1:0] pendVal_r;
  logic [`E3OH_OH_BITS-1:0] pendFlagNxt;
  logic [`E3OH_OH_BITS-1:0] pendValNxt;
  logic                   pipeOh_r  [`E3OH_SYNC_LATENCY];
  e3oh_pkg::e3oh_idx_t    pipeIdx_r [`E3OH_SYNC_LATENCY];
  logic [1:0]             pinSync;
  logic [FIFO_WIDTH-1:0]  fifoData;
  logic                   fifoValid;

  wire lastBit   = (bitCnt_r == `E3OH_LAST_BIT);
  wire lastCol   = (colCnt_r == `E3OH_LAST_COL);
  wire lastRow   = (rowCnt_r == `E3OH_LAST_ROW);
  wire leadOh    = isOhPos(rowCnt_r, colCnt_r);
  wire leadFrame = (rowCnt_r == 4'h0) && (colCnt_r == 6'h00) && (bitCnt_r == 3'h0);
  wire e3oh_pkg::e3oh_idx_t leadIdx = leadFrame ? 6'h00 : ohCnt_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bitCnt_r <= 3'h0;
      colCnt_r <= 6'h00;
      rowCnt_r <= 4'h0;
      ohCnt_r  <= 6'h00;
    end else begin
      bitCnt_r <= bitCnt_r + 3'h1;
      if (lastBit) begin
        colCnt_r <= lastCol ? 6'h00 : colCnt_r + 6'h01;
        if (lastCol) begin
          rowCnt_r <= lastRow ? 4'h0 : rowCnt_r + 4'h1;
        end
      end
      if (leadOh) begin
        ohCnt_r <= leadIdx + 6'h01;
      end
    end
  end

  // Strobes lead the processed bit by one clock and last one clock each
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      frameBoundaryStrobe <= 1'b0;
      overheadBitStrobe   <= 1'b0;
      s1Idx_r             <= 6'h00;
      s1Bit_r             <= 3'h0;
    end else begin
      frameBoundaryStrobe <= leadFrame;
      overheadBitStrobe   <= leadOh;
      s1Idx_r             <= leadIdx;
      s1Bit_r             <= bitCnt_r;
    end
  end

  // Insert pins cross from the terminal, so the strobe index is delayed to match
  e3oh_sync #(
    .WIDTH (2)
  ) uPinSync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .din      ({overheadInsertRequest, overheadDataInput}),
    .dout     (pinSync)
  );

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < `E3OH_SYNC_LATENCY; i++) begin
        pipeOh_r[i]  <= 1'b0;
        pipeIdx_r[i] <= 6'h00;
      end
    end else begin
      pipeOh_r[0]  <= overheadBitStrobe;
      pipeIdx_r[0] <= s1Idx_r;
      for (int i = 1; i < `E3OH_SYNC_LATENCY; i++) begin
        pipeOh_r[i]  <= pipeOh_r[i-1];
        pipeIdx_r[i] <= pipeIdx_r[i-1];
      end
    end
  end

  wire e3oh_pkg::e3oh_idx_t accIdx = pipeIdx_r[`E3OH_SYNC_LATENCY-1];
  wire accept  = pipeOh_r[`E3OH_SYNC_LATENCY-1] && pinSync[1] && isInsertable(accIdx);
  wire consume = overheadBitStrobe && isInsertable(s1Idx_r) && pendFlag_r[s1Idx_r];

  // Set wins over consume; the two never meet on the same bit anyway
  genvar g;
  generate
    for (g = 0; g < `E3OH_OH_BITS; g++) begin : gPend
      wire hitAcc = accept && (accIdx == 6'(g));
      wire hitUse = consume && (s1Idx_r == 6'(g));
      assign pendFlagNxt[g] = hitAcc ? 1'b1 : (hitUse ? 1'b0 : pendFlag_r[g]);
      assign pendValNxt[g]  = hitAcc ? pinSync[0] : pendVal_r[g];
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pendFlag_r <= '0;
      pendVal_r  <= '0;
    end else begin
      pendFlag_r <= pendFlagNxt;
      pendVal_r  <= pendValNxt;
    end
  end

  // Overhead bit selection for the position being processed
  wire [2:0] laneSel   = ~s1Idx_r[2:0];
  wire       isEm      = (s1Idx_r >= `E3OH_FIRST_EM_IDX) && (s1Idx_r <= `E3OH_LAST_EM_IDX);
  wire       emBit     = bipPrev_r[laneSel];
  wire e3oh_pkg::e3oh_byte_t dflt = defaultByte(s1Idx_r[5:3]);
  wire       dfltBit   = dflt[laneSel];
  wire       ohBit     = isEm ? emBit : (consume ? pendVal_r[s1Idx_r] : dfltBit);

  // Payload serialiser; an empty FIFO sends idle fill rather than stalling the line
  wire       byteStart = !overheadBitStrobe && (s1Bit_r == 3'h0);
  wire [7:0] newByte   = fifoValid ? fifoData : `E3OH_IDLE_FILL;
  wire       payBit    = byteStart ? newByte[7] : payShift_r[7];
  wire       outBit    = overheadBitStrobe ? ohBit : payBit;
  wire [7:0] laneMask  = 8'h80 >> s1Bit_r;
  wire [7:0] bipBase   = frameBoundaryStrobe ? 8'h00 : bipAcc_r;
  wire [7:0] bipNxt    = bipBase ^ (outBit ? laneMask : 8'h00);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      payShift_r       <= 8'h00;
      bipAcc_r         <= 8'h00;
      bipPrev_r        <= 8'h00;
      lineLive_r       <= 1'b0;
      txLineData       <= 1'b0;
      txLineFrameStart <= 1'b0;
    end else begin
      payShift_r       <= byteStart ? {newByte[6:0], 1'b0} : {payShift_r[6:0], 1'b0};
      bipAcc_r         <= bipNxt;
      // Bits sent before the first frame must not seed the first error monitor byte
      if (frameBoundaryStrobe) begin
        bipPrev_r  <= lineLive_r ? bipAcc_r : 8'h00;
        lineLive_r <= 1'b1;
      end
      txLineData       <= outBit;
      txLineFrameStart <= frameBoundaryStrobe;
    end
  end

  e3oh_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) uPayFifo (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .inData   (payloadData),
    .inValid  (payloadValid),
    .inReady  (payloadReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (byteStart)
  );

  chk_frame_joint: assert property (@(posedge core_clk) disable iff (!rst_n)
    frameBoundaryStrobe |-> overheadBitStrobe && s1Idx_r == 6'h00)
    else $error("frame strobe without overhead strobe at index zero");

  chk_framing_burst: assert property (@(posedge core_clk) disable iff (!rst_n)
    frameBoundaryStrobe |-> overheadBitStrobe[*8] ##1 overheadBitStrobe[*8] ##1 !overheadBitStrobe)
    else $error("framing bytes not sixteen contiguous strobes");

  chk_fa1_on_line: assert property (@(posedge core_clk) disable iff (!rst_n)
    frameBoundaryStrobe |=> txLineData == 1'b1 && txLineFrameStart)
    else $error("first framing bit not on line one clock after strobe");

  chk_em_refused: assert property (@(posedge core_clk) disable iff (!rst_n)
    (overheadBitStrobe && isEm) |=> txLineData == $past(emBit))
    else $error("error monitor bit not internally generated");

  chk_no_fixed_ins: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pipeOh_r[2] && pinSync[1] && pipeIdx_r[2] < `E3OH_FIRST_INS_IDX) |=> pendFlag_r[$past(accIdx)] == 1'b0)
    else $error("insert accepted at non-insertable position");

  chk_ignore_low: assert property (@(posedge core_clk) disable iff (!rst_n)
    !pinSync[1] |-> !accept)
    else $error("insert accepted while request low");

  chk_accept_store: assert property (@(posedge core_clk) disable iff (!rst_n)
    accept |=> pendFlag_r[$past(accIdx)] && pendVal_r[$past(accIdx)] == $past(pinSync[0]))
    else $error("accepted bit not stored");

  chk_insert_used: assert property (@(posedge core_clk) disable iff (!rst_n)
    consume |=> txLineData == $past(pendVal_r[s1Idx_r]) && !pendFlag_r[$past(s1Idx_r)])
    else $error("stored bit not sent in next frame");

  chk_default_used: assert property (@(posedge core_clk) disable iff (!rst_n)
    (overheadBitStrobe && isInsertable(s1Idx_r) && !pendFlag_r[s1Idx_r]) |=> txLineData == $past(dfltBit))
    else $error("internal overhead value not sent");

  chk_strobe_count: assert property (@(posedge core_clk) disable iff (!rst_n)
    (overheadBitStrobe && s1Idx_r == 6'h37) |=> !overheadBitStrobe ##0 (ohCnt_r == 6'h38) || leadFrame)
    else $error("overhead count past fifty-five");

  chk_frame_single: assert property (@(posedge core_clk) disable iff (!rst_n)
    frameBoundaryStrobe |=> !frameBoundaryStrobe)
    else $error("frame strobe longer than one clock");

  chk_line_start: assert property (@(posedge core_clk) disable iff (!rst_n)
    txLineFrameStart |-> $past(frameBoundaryStrobe))
    else $error("line frame start without frame strobe");

  chk_fa_internal: assert property (@(posedge core_clk) disable iff (!rst_n)
    (overheadBitStrobe && s1Idx_r <= 6'h0f) |=> txLineData == $past(dfltBit))
    else $error("framing bit not internally generated");

  chk_oh_aligned: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(overheadBitStrobe) |-> s1Bit_r == 3'h0 && s1Idx_r[2:0] == 3'h0)
    else $error("overhead burst not byte aligned");

  chk_burst_end: assert property (@(posedge core_clk) disable iff (!rst_n)
    (overheadBitStrobe && s1Idx_r[2:0] == 3'h7 && s1Idx_r[5:3] != 3'h0) |=> !overheadBitStrobe)
    else $error("overhead strobe runs past its byte");

  chk_refused_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
    pendFlag_r[23:0] == 24'h000000)
    else $error("non-insertable position holds a stored bit");

  chk_ma_insert: assert property (@(posedge core_clk) disable iff (!rst_n)
    (consume && s1Idx_r[5:1] == 5'h10) |=> txLineData == $past(pendVal_r[s1Idx_r]))
    else $error("maintenance bit insert not sent");

  chk_first_em_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (frameBoundaryStrobe && !lineLive_r) |=> bipPrev_r == 8'h00)
    else $error("first error monitor byte not zero");

  chk_strobe_lead: assert property (@(posedge core_clk) disable iff (!rst_n)
    overheadBitStrobe |=> txLineData == $past(ohBit))
    else $error("overhead bit not on line after its strobe");
endmodule
`default_nettype wire

// file: e3oh_regs.svh
// Constants of the E3 transmit overhead insertion port
`ifndef E3OH_REGS_SVH
`define E3OH_REGS_SVH

`define E3OH_LAST_BIT      3'h7
`define E3OH_LAST_COL      6'h3a
`define E3OH_LAST_ROW      4'h8
`define E3OH_OH_ROW_LAST   4'h5
`define E3OH_OH_BITS       56
`define E3OH_FIRST_EM_IDX  6'h10
`define E3OH_LAST_EM_IDX   6'h17
`define E3OH_FIRST_INS_IDX 6'h18
`define E3OH_LAST_INS_IDX  6'h37
`define E3OH_FA1_VALUE     8'hf6
`define E3OH_FA2_VALUE     8'h28
`define E3OH_TR_DEFAULT    8'h00
`define E3OH_MA_DEFAULT    8'h00
`define E3OH_NR_DEFAULT    8'h00
`define E3OH_GC_DEFAULT    8'h00
`define E3OH_IDLE_FILL     8'hff
`define E3OH_SYNC_LATENCY  3

`endif

// file: e3oh_pkg.sv
// Types shared by the E3 transmit overhead insertion port
`default_nettype none
package e3oh_pkg;
  typedef logic [5:0] e3oh_idx_t;
  typedef logic [7:0] e3oh_byte_t;
  typedef enum logic [6:0] {
    E3OH_FA1 = 7'h01,
    E3OH_FA2 = 7'h02,
    E3OH_EM  = 7'h04,
    E3OH_TR  = 7'h08,
    E3OH_MA  = 7'h10,
    E3OH_NR  = 7'h20,
    E3OH_GC  = 7'h40
  } e3oh_field_e;
endpackage
`default_nettype wire

// file: e3oh_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module e3oh_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1_r;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stage1_r <= '0;
      dout     <= '0;
    end else begin
      stage1_r <= din;
      dout     <= stage1_r;
    end
  end
endmodule
`default_nettype wire

// file: e3oh_fifo.sv
// Payload FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module e3oh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_r;
  logic [AW-1:0]    rdPtr_r;
  logic [AW:0]      count_r;

  wire doPush = inValid && inReady;
  wire doPop  = outValid && outReady;
  wire [AW-1:0] wrPtrNxt = (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
  wire [AW-1:0] rdPtrNxt = (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;

  assign inReady  = (count_r != (AW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData  = mem[rdPtr_r];

  always_ff @(posedge core_clk) begin
    if (doPush) begin
      mem[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (doPush) begin
        wrPtr_r <= wrPtrNxt;
      end
      if (doPop) begin
        rdPtr_r <= rdPtrNxt;
      end
      count_r <= count_r + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end
endmodule
`default_nettype wire

// file: e3oh_term_model.sv
// Terminal equipment model that feeds overhead bits to the insertion port
`timescale 1ns/1ns
`default_nettype none
module e3oh_term_model (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        frameBoundaryStrobe,
  input  wire logic        overheadBitStrobe,
  input  wire logic [55:0] insMask,
  input  wire logic [55:0] insVal,
  output var  logic        overheadInsertRequest,
  output var  logic        overheadDataInput
);
  logic [5:0] idx_r;
  logic [5:0] curIdx;
  logic       reqPend_r;
  logic       datPend_r;

  // Joint strobes restart the count at zero
  assign curIdx = frameBoundaryStrobe ? 6'h00 : idx_r + 6'h01;

  initial begin
    overheadInsertRequest = 1'b0;
    overheadDataInput = 1'b0;
  end

  // Both strobes sampled on the line clock
  always @(posedge core_clk) begin
    if (!rst_n) begin
      idx_r <= 6'h3f;
      reqPend_r <= 1'b0;
      datPend_r <= 1'b0;
    end else if (overheadBitStrobe) begin
      idx_r <= curIdx;
      reqPend_r <= insMask[curIdx];
      datPend_r <= insMask[curIdx] ? insVal[curIdx] : ~datPend_r;
    end else if (!reqPend_r) begin
      // Unqualified data keeps moving so a device that samples it shows up
      datPend_r <= ~datPend_r;
    end
  end

  // Driven half a cycle later; request held until the next strobe, data held only while request is high
  always @(negedge core_clk) begin
    overheadInsertRequest <= reqPend_r;
    overheadDataInput <= datPend_r;
  end
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the E3 transmit overhead insertion port
`timescale 1ns/1ns
`include "e3oh_regs.svh"
`default_nettype none
module testbench;
  localparam logic [55:0] DFLT = {`E3OH_FA1_VALUE, `E3OH_FA2_VALUE, 8'h00, `E3OH_TR_DEFAULT,
                                  `E3OH_MA_DEFAULT, `E3OH_NR_DEFAULT, `E3OH_GC_DEFAULT};
  logic        core_clk = 1'b0;
  logic        rst_n;
  logic        overheadInsertRequest;
  logic        overheadDataInput;
  logic        frameBoundaryStrobe;
  logic        overheadBitStrobe;
  logic [7:0]  payloadData;
  logic        payloadValid;
  logic        payloadReady;
  logic        txLineData;
  logic        txLineFrameStart;
  logic [55:0] insMask;
  logic [55:0] insVal;
  logic        oq[$];
  logic [7:0]  pq[$];
  int          err_count;
  int          num_checks;
  int          refused;
  logic        lastStb;
  logic        started;
  logic        e;
  logic [5:0]  k;
  logic [7:0]  bip;
  logic [7:0]  prevBip;
  logic [7:0]  pbyte;
  int          pos;
  int          pbits;

  always #5 core_clk = ~core_clk;

  e3oh_tx_overhead u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .overheadInsertRequest(overheadInsertRequest),
    .overheadDataInput(overheadDataInput), .frameBoundaryStrobe(frameBoundaryStrobe),
    .overheadBitStrobe(overheadBitStrobe), .payloadData(payloadData), .payloadValid(payloadValid),
    .payloadReady(payloadReady), .txLineData(txLineData), .txLineFrameStart(txLineFrameStart));

  e3oh_term_model u_term (
    .core_clk(core_clk), .rst_n(rst_n), .frameBoundaryStrobe(frameBoundaryStrobe),
    .overheadBitStrobe(overheadBitStrobe), .insMask(insMask), .insVal(insVal),
    .overheadInsertRequest(overheadInsertRequest), .overheadDataInput(overheadDataInput));

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp_bit(input logic exp, input logic got, input string what);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t %s exp %b got %b", $time, what, exp, got);
    end
  endtask

  task automatic cmp_byte(input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t payload exp %h got %h", $time, exp, got);
    end
  endtask

  // Next frame's overhead: inserted bits only where insertion is allowed
  task automatic push_expect(input logic [55:0] m, input logic [55:0] v);
    for (int i = 0; i < 56; i++) begin
      if (i >= `E3OH_FIRST_INS_IDX && m[i]) oq.push_back(v[i]);
      else oq.push_back(DFLT[55-i]);
    end
  endtask

  task automatic wait_frame();
    int g;
    g = 0;
    @(negedge core_clk);
    while (frameBoundaryStrobe !== 1'b1 && g < 6000) begin
      @(negedge core_clk);
      g++;
    end
    if (g >= 6000) begin
      cmp_bit(1'b1, 1'b0, "frame boundary timeout");
      report_and_stop();
    end
  endtask

  // Offers more bytes than the buffer holds, so it must refuse for a while
  task automatic fill_payload();
    int  i;
    int  g;
    logic acc;
    i = 0;
    payloadData = 8'($urandom) & 8'h7f;
    payloadValid = 1'b1;
    for (g = 0; i < 48 && g < 3000; g++) begin
      acc = (payloadReady === 1'b1);
      if (acc) pq.push_back(payloadData);
      else refused++;
      @(negedge core_clk);
      if (acc) begin
        i++;
        payloadData = 8'($urandom) & 8'h7f;
      end
    end
    payloadValid = 1'b0;
    if (i < 48) begin
      cmp_bit(1'b1, 1'b0, "payload offer timeout");
      report_and_stop();
    end
  endtask

  // Line watcher: overhead bit follows its strobe by one cycle, the rest is payload
  always @(negedge core_clk) begin
    if (rst_n !== 1'b1) begin
      lastStb = 1'b0;
      started = 1'b0;
      prevBip = 8'h00;
      k = 6'h00;
    end else begin
      if (txLineFrameStart === 1'b1) begin
        if (started) prevBip = bip;
        bip = 8'h00;
        pos = 0;
        pbits = 0;
        started = 1'b1;
      end
      if (started) begin
        bip[7 - pos % 8] = bip[7 - pos % 8] ^ txLineData;
        pos++;
        if (lastStb && oq.size() > 0) begin
          e = oq.pop_front();
          if (k >= 6'd16 && k <= 6'd23) e = prevBip[6'd23 - k];
          cmp_bit(e, txLineData, "overhead bit");
        end else if (!lastStb) begin
          pbyte = {pbyte[6:0], txLineData};
          pbits++;
          if (pbits == 8) begin
            pbits = 0;
            if (pbyte !== 8'hff) cmp_byte(pq.size() > 0 ? pq.pop_front() : 8'hff, pbyte);
          end
        end
      end
      if (overheadBitStrobe === 1'b1) begin
        if (frameBoundaryStrobe === 1'b1 && started) cmp_bit(1'b1, k == 6'd55, "strobes per frame");
        k = (frameBoundaryStrobe === 1'b1) ? 6'h00 : k + 6'h01;
      end else if (frameBoundaryStrobe === 1'b1) cmp_bit(1'b0, 1'b1, "lone frame strobe");
      lastStb = (overheadBitStrobe === 1'b1);
    end
  end

  initial begin
    void'($urandom(28990));
    rst_n = 1'b0;
    payloadValid = 1'b0;
    payloadData = 8'h00;
    insMask = '0;
    insVal = '0;
    err_count = 0;
    num_checks = 0;
    refused = 0;
    push_expect('0, '0);
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    for (int f = 0; f < 4; f++) begin
      wait_frame();
      case (f)
        0: begin
          insMask = {56{1'b1}};
          insVal = 56'({$urandom, $urandom});
        end
        1: insMask = '0;
        2: begin
          insMask = 56'h3 << 32;
          insVal = 56'h3 << 32;
        end
        default: begin
          insMask = 56'({$urandom, $urandom});
          insVal = 56'({$urandom, $urandom});
        end
      endcase
      push_expect(insMask, insVal);
      if (f == 0 || f == 2) fill_payload();
    end
    wait_frame();
    insMask = '0;
    for (int g = 0; g < 6000 && (oq.size() > 0 || pq.size() > 0); g++) @(negedge core_clk);
    cmp_bit(1'b1, oq.size() == 0 && pq.size() == 0 && refused > 0, "drain and refusal");
    report_and_stop();
  end
endmodule
`default_nettype wire
